// [common/gmn_pkg.sv]
// Package of constants for the guarded multiply, negate and compare datapath
`default_nettype none
package gmn_pkg;
	// ==========================================================
	// Widths
	localparam int DATA_W  = 32;
	localparam int PROD_W  = 64;
	localparam int IMM_W   = 7;
	localparam int REG_W   = 7;
	// ==========================================================
	// Timing
	localparam int MUL_LAT = 3;
	localparam int ALU_LAT = 1;
	// ==========================================================
	// Values
	localparam logic [31:0] ZERO_VAL = 32'h0000_0000;
	localparam logic [31:0] MOST_NEG = 32'h8000_0000;
	localparam logic [6:0]  ZERO_REG = 7'h00;
	// ==========================================================
	// Operation selects
	typedef enum logic [2:0] {
		GMN_OP_MUL_LO,
		GMN_OP_MUL_HI,
		GMN_OP_NEG,
		GMN_OP_NEQ,
		GMN_OP_NEQ_IMM,
		GMN_OP_NONE
	} gmn_op_t;
endpackage
`default_nettype wire

// [design/gmn_mul_pipe.sv]
// Two-stage signed multiplier core with tag passthrough
`default_nettype none
module gmn_mul_pipe #(
	parameter int DATA_W = 32,
	parameter int TAG_W  = 9
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                reset_n,
	// Issue side
	input  wire logic                in_valid,
	input  wire logic                in_high,
	input  wire logic [TAG_W-1:0]    in_tag,
	input  wire logic [DATA_W-1:0]   in_a,
	input  wire logic [DATA_W-1:0]   in_b,
	// Result side
	output logic                     out_valid,
	output logic [TAG_W-1:0]         out_tag,
	output logic [DATA_W-1:0]        out_result
);
	// ==========================================================
	// Stage 1: capture operands
	logic                   v1_q, v2_q, h1_q, h2_q;
	logic [TAG_W-1:0]       t1_q, t2_q;
	logic signed [DATA_W-1:0] a1_q, b1_q;
	logic signed [2*DATA_W-1:0] p2_q;
	wire  signed [2*DATA_W-1:0] prod_w;
	wire  [DATA_W-1:0]          pick_w;

	// Signed operands sign-extend to the full product width
	assign prod_w = a1_q * b1_q;
	// Upper half for the high variant, lower half otherwise
	assign pick_w = h2_q ? p2_q[2*DATA_W-1:DATA_W]
		: p2_q[DATA_W-1:0];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			v1_q      <= 1'b0;
			v2_q      <= 1'b0;
		end else begin
			v1_q      <= in_valid;
			v2_q      <= v1_q;
		end
	end

	// Final select is left unregistered: the parent's output flop is
	// the third stage, which keeps the issue-to-write delay at three
	assign out_valid  = v2_q;
	assign out_tag    = t2_q;
	assign out_result = pick_w;

	// Datapath flops cleared as well so no unknown reaches the outputs
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			a1_q       <= '0;
			b1_q       <= '0;
			h1_q       <= 1'b0;
			t1_q       <= '0;
			p2_q       <= '0;
			h2_q       <= 1'b0;
			t2_q       <= '0;
		end else begin
			a1_q       <= in_a;
			b1_q       <= in_b;
			h1_q       <= in_high;
			t1_q       <= in_tag;
			p2_q       <= prod_w;
			h2_q       <= h1_q;
			t2_q       <= t1_q;
		end
	end
endmodule
`default_nettype wire

// [design/gmn_exec.sv]
// Guarded multiply, negate and not-equal compare execution unit
// ==========================================================
// Overview of operation
// - Low multiply writes product bits 31:0
// - Low multiply never flags overflow
// - Multiply operands are signed two's complement
// - Guard LSB one enables destination write
// - High multiply writes product bits 63:32
// - Zero register always reads zero
// - Negate writes zero minus source
// - Negating most negative returns it unchanged
// - Register compare writes one when differing
// - Immediate compare against signed 7-bit value
`default_nettype none
module gmn_exec #(
	parameter int DATA_W = 32,
	parameter int REG_W  = 7
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                reset_n,
	// Issue
	input  wire logic                issue_valid,
	input  wire gmn_pkg::gmn_op_t    issue_op,
	input  wire logic [REG_W-1:0]    first_source_index,
	input  wire logic [REG_W-1:0]    second_source_index,
	input  wire logic [DATA_W-1:0]   first_source_operand,
	input  wire logic [DATA_W-1:0]   second_source_operand,
	input  wire logic [6:0]          immediate,
	input  wire logic                guard_present,
	input  wire logic [DATA_W-1:0]   guard_value,
	input  wire logic [REG_W-1:0]    dest_index,
	// Integer unit write port
	output logic                     alu_write,
	output logic [REG_W-1:0]         alu_dest,
	output logic [DATA_W-1:0]        alu_data,
	// Multiplier write port
	output logic                     mul_write,
	output logic [REG_W-1:0]         mul_dest,
	output logic [DATA_W-1:0]        mul_data
);
	// ==========================================================
	// Operand decode
	wire [DATA_W-1:0] src1_w;
	wire [DATA_W-1:0] src2_w;
	wire [DATA_W-1:0] imm_ext_w;
	wire              guard_ok_w;
	wire              is_mul_w;
	wire              is_alu_w;
	wire [DATA_W-1:0] neg_w;
	wire [DATA_W-1:0] alu_res_w;

	// Register zero forced to zero whatever the file delivers
	assign src1_w = (first_source_index == gmn_pkg::ZERO_REG)
		? gmn_pkg::ZERO_VAL : first_source_operand;
	assign src2_w = (second_source_index == gmn_pkg::ZERO_REG)
		? gmn_pkg::ZERO_VAL : second_source_operand;
	assign imm_ext_w = {{(DATA_W-7){immediate[6]}}, immediate};
	assign guard_ok_w = !guard_present || guard_value[0];
	assign is_mul_w = issue_valid && guard_ok_w
		&& (issue_op == gmn_pkg::GMN_OP_MUL_LO
		|| issue_op == gmn_pkg::GMN_OP_MUL_HI);
	assign is_alu_w = issue_valid && guard_ok_w
		&& (issue_op == gmn_pkg::GMN_OP_NEG
		|| issue_op == gmn_pkg::GMN_OP_NEQ
		|| issue_op == gmn_pkg::GMN_OP_NEQ_IMM);

	// Wraps modulo 2^32, so the most negative value maps to itself
	assign neg_w = gmn_pkg::ZERO_VAL - src1_w;

	assign alu_res_w =
		(issue_op == gmn_pkg::GMN_OP_NEG) ? neg_w :
		(issue_op == gmn_pkg::GMN_OP_NEQ)
			? {{(DATA_W-1){1'b0}}, src1_w != src2_w} :
		{{(DATA_W-1){1'b0}}, src1_w != imm_ext_w};

	// ==========================================================
	// Single-cycle integer unit
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			alu_write <= 1'b0;
			alu_dest  <= '0;
			alu_data  <= '0;
		end else begin
			alu_write <= is_alu_w;
			alu_dest  <= dest_index;
			alu_data  <= alu_res_w;
		end
	end

	// ==========================================================
	// Pipelined multiplier; no overflow indication exists
	wire              mul_v_w;
	wire [REG_W-1:0]  mul_t_w;
	wire [DATA_W-1:0] mul_r_w;

	gmn_mul_pipe #(
		.DATA_W (DATA_W),
		.TAG_W  (REG_W)
	) u_mul (
		.clock      (clock),
		.reset_n    (reset_n),
		.in_valid   (is_mul_w),
		.in_high    (issue_op == gmn_pkg::GMN_OP_MUL_HI),
		.in_tag     (dest_index),
		.in_a       (src1_w),
		.in_b       (src2_w),
		.out_valid  (mul_v_w),
		.out_tag    (mul_t_w),
		.out_result (mul_r_w)
	);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mul_write <= 1'b0;
			mul_dest  <= '0;
			mul_data  <= '0;
		end else begin
			mul_write <= mul_v_w;
			mul_dest  <= mul_t_w;
			mul_data  <= mul_r_w;
		end
	end

	// ==========================================================
	// Checks
	logic signed [63:0] prod_chk;
	assign prod_chk = $signed(src1_w) * $signed(src2_w);

	sequence s_mul_lo;
		issue_valid && guard_ok_w && issue_op == gmn_pkg::GMN_OP_MUL_LO;
	endsequence
	sequence s_mul_hi;
		issue_valid && guard_ok_w && issue_op == gmn_pkg::GMN_OP_MUL_HI;
	endsequence

	property p_mul_lo;
		@(posedge clock) disable iff (!reset_n)
		s_mul_lo |-> ##3 (mul_write
			&& mul_data == $past(prod_chk[31:0], 3));
	endproperty
	a_mul_lo: assert property (p_mul_lo) else $error("low product wrong");

	property p_mul_hi;
		@(posedge clock) disable iff (!reset_n)
		s_mul_hi |-> ##3 (mul_write
			&& mul_data == $past(prod_chk[63:32], 3));
	endproperty
	a_mul_hi: assert property (p_mul_hi) else $error("high product wrong");

	property p_guard;
		@(posedge clock) disable iff (!reset_n)
		(issue_valid && guard_present && !guard_value[0]) |=> !alu_write;
	endproperty
	a_guard: assert property (p_guard) else $error("write despite guard");

	property p_neg;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEG)
			|=> alu_data == ~$past(src1_w) + 32'h0000_0001;
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");

	property p_neg_min;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEG
			&& src1_w == gmn_pkg::MOST_NEG) |=> alu_data == 32'h8000_0000;
	endproperty
	a_neg_min: assert property (p_neg_min) else $error("min negate");

	property p_zero_reg;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEG
			&& first_source_index == 7'h00) |=> alu_data == 32'h0000_0000;
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("zero reg");

	property p_neq;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEQ)
			|=> alu_data == {31'h0, $past(src1_w != src2_w)};
	endproperty
	a_neq: assert property (p_neq) else $error("compare wrong");

	property p_neqi;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEQ_IMM)
			|=> alu_data == {31'h0,
			$past($signed(src1_w) != $signed(immediate))};
	endproperty
	a_neqi: assert property (p_neqi) else $error("imm compare wrong");

	property p_lat;
		@(posedge clock) disable iff (!reset_n)
		mul_write |-> $past(is_mul_w, 3);
	endproperty
	a_lat: assert property (p_lat) else $error("mul latency");

	// ==========================================================
	// Check helpers
	// Multiplies taken but not yet written back; a write strobe with
	// nothing in flight would be a phantom result
	logic [1:0]       mul_pend_q;
	wire  [1:0]       mul_pend_d;
	gmn_pkg::gmn_op_t alu_op_q;

	// Three in flight at most, so two bits never wrap
	assign mul_pend_d = (is_mul_w && !mul_write) ? mul_pend_q + 2'h1
		: (!is_mul_w && mul_write) ? mul_pend_q - 2'h1
		: mul_pend_q;

	// Operation behind the current integer unit strobe
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mul_pend_q <= 2'h0;
			alu_op_q   <= gmn_pkg::GMN_OP_NONE;
		end else begin
			mul_pend_q <= mul_pend_d;
			alu_op_q   <= issue_op;
		end
	end

	sequence s_guard_off;
		issue_valid && guard_present && !guard_value[0];
	endsequence
	sequence s_mul_any;
		is_mul_w;
	endsequence
	sequence s_alu_any;
		is_alu_w;
	endsequence

	// A refused guard leaves both write ports idle
	property p_guard_mul;
		@(posedge clock) disable iff (!reset_n)
		s_guard_off |-> ##3 !mul_write;
	endproperty
	a_guard_mul: assert property (p_guard_mul)
		else $error("mul write despite guard");

	property p_mul_quiet;
		@(posedge clock) disable iff (!reset_n)
		!is_mul_w |-> ##3 !mul_write;
	endproperty
	a_mul_quiet: assert property (p_mul_quiet)
		else $error("mul write without issue");

	property p_alu_quiet;
		@(posedge clock) disable iff (!reset_n)
		!is_alu_w |=> !alu_write;
	endproperty
	a_alu_quiet: assert property (p_alu_quiet)
		else $error("alu write without issue");

	// Result lands in the slot named at issue, after the fixed delay
	property p_alu_dest;
		@(posedge clock) disable iff (!reset_n)
		s_alu_any |=> alu_write && alu_dest == $past(dest_index);
	endproperty
	a_alu_dest: assert property (p_alu_dest)
		else $error("alu destination wrong");

	property p_mul_dest;
		@(posedge clock) disable iff (!reset_n)
		s_mul_any |-> ##3 (mul_write
			&& mul_dest == $past(dest_index, 3));
	endproperty
	a_mul_dest: assert property (p_mul_dest)
		else $error("mul destination wrong");

	property p_mul_pend;
		@(posedge clock) disable iff (!reset_n)
		mul_write |-> mul_pend_q != 2'h0;
	endproperty
	a_mul_pend: assert property (p_mul_pend)
		else $error("mul write with nothing in flight");

	// Compares hand back a single flag bit, never a wider value
	property p_cmp_bool;
		@(posedge clock) disable iff (!reset_n)
		(alu_write && (alu_op_q == gmn_pkg::GMN_OP_NEQ
			|| alu_op_q == gmn_pkg::GMN_OP_NEQ_IMM))
			|-> alu_data[DATA_W-1:1] == '0;
	endproperty
	a_cmp_bool: assert property (p_cmp_bool)
		else $error("compare result not a flag");

	property p_neq_same;
		@(posedge clock) disable iff (!reset_n)
		(is_alu_w && issue_op == gmn_pkg::GMN_OP_NEQ
			&& first_source_index == second_source_index)
			|=> alu_data == '0;
	endproperty
	a_neq_same: assert property (p_neq_same)
		else $error("same register compared unequal");

	// Zero register feeds the multiplier too, whatever the file holds
	property p_mul_zero;
		@(posedge clock) disable iff (!reset_n)
		(is_mul_w && first_source_index == gmn_pkg::ZERO_REG)
			|-> ##3 mul_data == '0;
	endproperty
	a_mul_zero: assert property (p_mul_zero)
		else $error("zero register leaked into product");

	// Outputs stay quiet while reset is held
	property p_reset_quiet;
		@(posedge clock)
		!reset_n |=> !alu_write && !mul_write;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("write strobe during reset");
endmodule
`default_nettype wire

// [verification/gmn_rf_model.sv]
// Register file model feeding operands to the execution unit
`default_nettype none
module gmn_rf_model (
	// Clock
	input  wire logic        clock,
	// Operand reads
	input  wire logic [6:0]  rd_a,
	input  wire logic [6:0]  rd_b,
	output logic      [31:0] rd_a_data,
	output logic      [31:0] rd_b_data,
	// Write ports
	input  wire logic        we_a,
	input  wire logic [6:0]  wa_a,
	input  wire logic [31:0] wd_a,
	input  wire logic        we_b,
	input  wire logic [6:0]  wa_b,
	input  wire logic [31:0] wd_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] file_q [128];
	// Slot zero holds junk: the unit must force zero itself
	initial file_q[0] = 32'hA5A5_A5A5;
	assign rd_a_data = file_q[rd_a];
	assign rd_b_data = file_q[rd_b];
	always @(posedge clock) begin
		if (we_a) file_q[wa_a] <= wd_a;
		if (we_b) file_q[wa_b] <= wd_b;
	end
endmodule
`default_nettype wire

// [verification/tb_gmn_exec.sv]
// Self-checking bench for the guarded execution unit
`default_nettype none
module tb_gmn_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clock = 1'b0;
	logic             reset_n = 1'b0;
	logic             valid = 1'b0;
	gmn_pkg::gmn_op_t op = gmn_pkg::GMN_OP_NONE;
	logic [6:0]       sa = 7'h00, sb = 7'h00, imm = 7'h00, dst = 7'h00;
	logic             g_on = 1'b0;
	logic [31:0]      g_val = 32'h0, opa, opb, adat, mdat;
	logic             aw, mw;
	logic [6:0]       ad, md;
	int               failures = 0, samples_checked = 0, cycles = 0;
	// ==========================================================
	// Instances
	gmn_exec gmn_exec_i (.clock(clock), .reset_n(reset_n),
		.issue_valid(valid), .issue_op(op), .first_source_index(sa),
		.second_source_index(sb), .first_source_operand(opa),
		.second_source_operand(opb), .immediate(imm),
		.guard_present(g_on), .guard_value(g_val), .dest_index(dst),
		.alu_write(aw), .alu_dest(ad), .alu_data(adat),
		.mul_write(mw), .mul_dest(md), .mul_data(mdat));
	gmn_rf_model gmn_rf_model_i (.clock(clock), .rd_a(sa), .rd_b(sb),
		.rd_a_data(opa), .rd_b_data(opb), .we_a(aw), .wa_a(ad),
		.wd_a(adat), .we_b(mw), .wa_b(md), .wd_b(mdat));
	// ==========================================================
	// Helpers
	initial forever #4 clock = ~clock;
	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [6:0] i, input logic [31:0] v);
		gmn_rf_model_i.file_q[i] = v;
	endtask
	task automatic iss(input gmn_pkg::gmn_op_t o, input logic [6:0] a, b,
			im, d, input logic [1:0] g);
		@(negedge clock);
		op = o; sa = a; sb = b; imm = im; dst = d;
		g_on = g[1];
		// Upper guard bits set so only bit zero may matter
		g_val = {31'h7FFF_FFFF, g[0]};
		valid = 1'b1;
	endtask
	task automatic settle(input int lat);
		int w;
		w = 0;
		@(negedge clock);
		valid = 1'b0;
		for (int n = 1; n < 9; n++) begin
			if (w == 0 && (aw === 1'b1 || mw === 1'b1)) w = n;
			@(negedge clock);
		end
		if (lat >= 0) chk("latency", w, lat);
	endtask
	task automatic run(input gmn_pkg::gmn_op_t o, input logic [6:0] a, b,
			im, input logic [1:0] g, input logic [31:0] e, input int lat);
		put(7'h50, 32'hDEAD_BEEF);
		iss(o, a, b, im, 7'h50, g);
		settle(lat);
		chk("dest", gmn_rf_model_i.file_q[7'h50], e);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_mul;
		put(7'h01, 32'hFFFF_FF00);
		put(7'h02, 32'hFFFF_FF9C);
		put(7'h03, 32'h0000_0064);
		put(7'h04, 32'h0001_0000);
		// Back to back through the pipelined multiplier
		iss(gmn_pkg::GMN_OP_MUL_LO, 7'h01, 7'h02, 7'h00, 7'h0A, 2'b11);
		iss(gmn_pkg::GMN_OP_MUL_HI, 7'h01, 7'h03, 7'h00, 7'h0B, 2'b00);
		iss(gmn_pkg::GMN_OP_MUL_HI, 7'h04, 7'h04, 7'h00, 7'h0C, 2'b00);
		iss(gmn_pkg::GMN_OP_MUL_LO, 7'h04, 7'h04, 7'h00, 7'h0D, 2'b00);
		settle(-1);
		chk("mul_lo", gmn_rf_model_i.file_q[7'h0A], 32'h0000_6400);
		chk("mul_hi", gmn_rf_model_i.file_q[7'h0B], 32'hFFFF_FFFF);
		chk("mul_hi", gmn_rf_model_i.file_q[7'h0C], 32'h0000_0001);
		chk("mul_lo", gmn_rf_model_i.file_q[7'h0D], 32'h0000_0000);
	endtask
	task automatic t_neg;
		logic [31:0] src [4] = '{32'hFFFF_FFF4, 32'h8000_0000,
			32'h8000_0001, 32'h0000_0001};
		logic [31:0] res [4] = '{32'h0000_000C, 32'h8000_0000,
			32'h7FFF_FFFF, 32'hFFFF_FFFF};
		for (int i = 0; i < 4; i++) begin
			put(7'h05, src[i]);
			run(gmn_pkg::GMN_OP_NEG, 7'h05, 7'h00, 7'h00, 2'b11, res[i], 1);
		end
	endtask
	task automatic t_neq;
		put(7'h06, 32'h0000_0003);
		put(7'h07, 32'h0000_0004);
		put(7'h08, 32'h0000_1000);
		put(7'h09, 32'hFFFF_FFC0);
		run(gmn_pkg::GMN_OP_NEQ, 7'h06, 7'h07, 7'h00, 2'b00, 32'h1, 1);
		run(gmn_pkg::GMN_OP_NEQ, 7'h08, 7'h08, 7'h00, 2'b00, 32'h0, 1);
		run(gmn_pkg::GMN_OP_NEQ_IMM, 7'h06, 7'h00, 7'h02, 2'b00, 32'h1, 1);
		run(gmn_pkg::GMN_OP_NEQ_IMM, 7'h06, 7'h00, 7'h03, 2'b00, 32'h0, 1);
		run(gmn_pkg::GMN_OP_NEQ_IMM, 7'h09, 7'h00, 7'h40, 2'b00, 32'h0, 1);
		run(gmn_pkg::GMN_OP_NEQ_IMM, 7'h08, 7'h00, 7'h3F, 2'b00, 32'h1, 1);
	endtask
	task automatic t_guard;
		put(7'h0E, 32'h0000_0000);
		run(gmn_pkg::GMN_OP_NEG, 7'h07, 7'h00, 7'h00, 2'b10, 32'hDEAD_BEEF, 0);
		run(gmn_pkg::GMN_OP_MUL_LO, 7'h07, 7'h07, 7'h00, 2'b10, 32'hDEAD_BEEF, 0);
		run(gmn_pkg::GMN_OP_NEQ, 7'h00, 7'h0E, 7'h00, 2'b11, 32'h0, 1);
		run(gmn_pkg::GMN_OP_NEG, 7'h00, 7'h00, 7'h00, 2'b00, 32'h0, 1);
		run(gmn_pkg::GMN_OP_NONE, 7'h06, 7'h07, 7'h00, 2'b00, 32'hDEAD_BEEF, 0);
		run(gmn_pkg::GMN_OP_MUL_LO, 7'h03, 7'h03, 7'h00, 2'b11, 32'h2710, 3);
		run(gmn_pkg::GMN_OP_MUL_HI, 7'h00, 7'h04, 7'h00, 2'b00, 32'h0, 3);
	endtask
	// ==========================================================
	// Verdict and sequence
	task automatic give_verdict;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		t_mul();
		t_neg();
		t_neq();
		t_guard();
		give_verdict();
	end
endmodule
`default_nettype wire
